/* File: mdps_pkg.sv */
// Constants, register map and carrier types of the multi-domain power sequencer.
// Assumes a single 40 MHz clock; rail and pin groups travel as packed structs.
package mdps_pkg;

    // Timebase
    localparam int CLK_HZ = 40_000_000;
    localparam int CYCLES_PER_MS = CLK_HZ / 1000;
    localparam int STAGE_DELAY_MS = 2;
    localparam int RESET_DELAY_MS = 50;
    localparam int CNT_W = 22;

    // Register byte offsets
    localparam logic [11:0] OFF_CONTROL = 12'h000;
    localparam logic [11:0] OFF_VOLTAGE = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;

    // Control register fields
    localparam int CTL_HOST_LEVEL = 0;
    localparam int CTL_MEM_SLEEP = 1;
    localparam int CTL_LDO2_SLEEP = 2;
    localparam int CTL_LDO3_SLEEP = 3;
    localparam int CTL_W = 4;
    localparam logic [3:0] CONTROL_RST = 4'he;

    // Voltage register fields, 25 mV per code: 1.1 V normal, 1.2 V sleep
    localparam int VID_W = 8;
    localparam int VID_SLEEP_LSB = 8;
    localparam logic [7:0] VID_NORMAL_RST = 8'h2c;
    localparam logic [7:0] VID_SLEEP_RST = 8'h30;

    // Open-drain pin indices
    localparam int OD_FULL_POWER = 0;
    localparam int OD_HOST = 1;
    localparam int OD_RESET = 2;
    localparam int OD_CORE = 3;

    // Domain levels
    localparam logic [1:0] LVL_OFF = 2'h0;
    localparam logic [1:0] LVL_FIRST = 2'h1;
    localparam logic [1:0] LVL_SECOND = 2'h2;
    localparam logic [1:0] LVL_SWITCH = 2'h3;

    // Main stages: number of rail groups enabled
    localparam logic [1:0] STG_NONE = 2'h0;
    localparam logic [1:0] STG_EARLY = 2'h1;
    localparam logic [1:0] STG_MID = 2'h2;

    typedef enum logic [1:0] {MS_OFF, MS_RAMP_UP, MS_ON, MS_RAMP_DOWN} mdps_main_e;

    typedef struct packed {
        logic resetRequest;
        logic auxSwitchEnable;
        logic fullPowerDomainEnable;
        logic mainPowerEnable;
        logic logicDomainEnable;
        logic sleepSelect;
    } mdps_ctl_s;

    typedef struct packed {
        logic standaloneSwitch;
        logic mergedSwitch;
        logic thirdLdo;
        logic secondLdo;
        logic transceiverLdo;
        logic terminationLdo;
        logic memoryBuck;
        logic [1:0] midBuck;
        logic [2:0] earlyBuck;
    } mdps_rails_s;

    typedef struct packed {
        logic memoryBuck;
        logic secondLdo;
        logic thirdLdo;
    } mdps_sleep_s;

    typedef struct packed {
        logic processorReleased;
        logic [1:0] logicLevel;
        logic [1:0] fullPowerLevel;
        logic [1:0] stage;
        mdps_main_e main;
        mdps_rails_s rails;
    } mdps_status_s;

endpackage : mdps_pkg

/* File: mdps_sequencer.sv */
// Pin-driven power sequencer with an APB register slave.
// Assumes control pins and power-good inputs are synchronous to mclk.
//
// Summary of operation
// RQ1 - Rails and outputs switch on only when control inputs and predecessor power-good agree.
// RQ2 - Rising main power enable starts the primary power-up sequence.
// RQ3 - Controller holds reset request and both domain enables high from the start.
// RQ4 - Always-on boards may tie both domain enables to main power enable.
// RQ5 - Sleep select low gives 1.2 V memory buck, high gives 1.1 V.
// RQ6 - Auxiliary switch enable drives standalone load switch directly, independent of sequence.
// RQ7 - Reset request low holds processor reset low; release 50 ms after it rises.
// RQ8 - Board may pull reset request low by pushbutton against a pull-up.
// RQ9 - Full-power and core switch outputs enable external load switches for low power.
// RQ10 - Full-power enable low cuts memory buck, transceiver, termination LDO, full-power switch.
// RQ11 - Logic enable low cuts merged switch, third LDO and core switch.
// RQ12 - Shared switch/LDO control acts on the transceiver LDO.
// RQ13 - Two low-voltage switches act merged; alternate shared fields have no effect.
// RQ14 - Host-adjustable settings stay writable over the bus after power-on.
// RQ15 - Memory buck defaults 1.1 V, sleep 1.2 V, 25 mV steps, sleep enabled.
// RQ16 - Second and third LDO sleep follows sleep select; transceiver LDO has none.
// RQ17 - Termination LDO enabled by full-power enable, faults not masked.
// RQ18 - Processor reset is open-drain from power-good; host output is register-set open-drain.
// RQ19 - Power-down disables groups in reverse order with fixed delay between.
// RQ20 - Domain enable returning high re-enables its rails staged with power-good gating.
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module mdps_sequencer
    import mdps_pkg::*;
#(
    parameter int STAGE_CYCLES = STAGE_DELAY_MS * CYCLES_PER_MS,
    parameter int RESET_CYCLES = RESET_DELAY_MS * CYCLES_PER_MS
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Control pins and rail feedback
    input wire mdps_ctl_s ctl,
    input wire mdps_rails_s pgood,
    // Rail enables and voltage selection
    output mdps_rails_s railEn,
    output logic [VID_W-1:0] memBuckVid,
    output mdps_sleep_s sleepMode,
    // Open-drain general outputs
    input wire logic [3:0] odIn,
    output logic [3:0] odOut,
    output logic [3:0] odOeN
);

    typedef struct packed {
        mdps_main_e main;
        logic [1:0] stage;
        logic [CNT_W-1:0] cnt;
        logic [1:0] fpLvl;
        logic [CNT_W-1:0] fpCnt;
        logic [1:0] lgLvl;
        logic [CNT_W-1:0] lgCnt;
        logic [CNT_W-1:0] porCnt;
        logic mainPrev;
        logic [CTL_W-1:0] control;
        logic [VID_W-1:0] vidNormal;
        logic [VID_W-1:0] vidSleep;
        mdps_rails_s rails;
        logic [VID_W-1:0] vid;
        mdps_sleep_s sleep;
        logic [3:0] oeN;
        logic [31:0] rdata;
        logic err;
    } mdps_state_s;

    mdps_state_s s;
    mdps_state_s next_s;
    mdps_status_s status;
    logic mainRise;
    logic stageDone;
    logic porReleased;

    function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c);
        bump = (&c) ? c : c + CNT_W'(1);
    endfunction : bump

    function automatic logic elapsed(input logic [CNT_W-1:0] c, input int lim);
        elapsed = c >= CNT_W'(lim);
    endfunction : elapsed

    function automatic logic groupGood(input logic [1:0] stg, input mdps_rails_s pg);
        if (stg == STG_EARLY)
        begin
            groupGood = &pg.earlyBuck;
        end
        else
        begin
            groupGood = (&pg.midBuck) & pg.secondLdo;
        end
    endfunction : groupGood

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == OFF_CONTROL) || (a == OFF_VOLTAGE) || (a == OFF_STATUS);
    endfunction : mapped

    assign mainRise = ctl.mainPowerEnable & ~s.mainPrev;
    assign stageDone = elapsed(s.cnt, STAGE_CYCLES);
    assign porReleased = elapsed(s.porCnt, RESET_CYCLES) && (s.main == MS_ON);

    always_comb
    begin
        status.processorReleased = s.oeN[OD_RESET];
        status.logicLevel = s.lgLvl;
        status.fullPowerLevel = s.fpLvl;
        status.stage = s.stage;
        status.main = s.main;
        status.rails = s.rails;
    end

    always_comb
    begin
        next_s = s;
        next_s.mainPrev = ctl.mainPowerEnable;

        // Main sequence over the always-present rail groups
        case (s.main)
            MS_OFF:
            begin
                if (mainRise) // RQ2
                begin
                    next_s.main = MS_RAMP_UP;
                    next_s.stage = STG_EARLY;
                    next_s.cnt = '0;
                end
            end
            MS_RAMP_UP:
            begin
                next_s.cnt = bump(s.cnt);
                if (!ctl.mainPowerEnable)
                begin
                    next_s.main = MS_RAMP_DOWN;
                    next_s.cnt = '0;
                end
                else if (stageDone && groupGood(s.stage, pgood)) // RQ1
                begin
                    next_s.cnt = '0;
                    if (s.stage == STG_MID)
                    begin
                        next_s.main = MS_ON;
                    end
                    else
                    begin
                        next_s.stage = STG_MID;
                    end
                end
            end
            MS_ON:
            begin
                if (!ctl.mainPowerEnable)
                begin
                    next_s.main = MS_RAMP_DOWN;
                    next_s.cnt = '0;
                end
            end
            MS_RAMP_DOWN:
            begin
                next_s.cnt = bump(s.cnt);
                if (stageDone) // RQ19
                begin
                    next_s.cnt = '0;
                    next_s.stage = s.stage - STG_EARLY;
                    if (s.stage == STG_EARLY)
                    begin
                        next_s.main = MS_OFF;
                    end
                end
            end
            default:
            begin
                next_s.main = MS_OFF;
            end
        endcase

        // Full-power domain: termination LDO, then memory buck and transceiver, then switch
        if (!ctl.fullPowerDomainEnable || next_s.main != MS_ON) // RQ10
        begin
            next_s.fpLvl = LVL_OFF;
            next_s.fpCnt = '0;
        end
        else if (s.fpLvl >= LVL_SECOND && !pgood.terminationLdo) // RQ17
        begin
            next_s.fpLvl = LVL_OFF;
            next_s.fpCnt = '0;
        end
        else if (s.fpLvl != LVL_SWITCH) // RQ20
        begin
            next_s.fpCnt = bump(s.fpCnt);
            if (elapsed(s.fpCnt, STAGE_CYCLES)
                && (s.fpLvl != LVL_FIRST || pgood.terminationLdo)
                && (s.fpLvl != LVL_SECOND || (pgood.memoryBuck && pgood.transceiverLdo))) // RQ1
            begin
                next_s.fpLvl = s.fpLvl + LVL_FIRST;
                next_s.fpCnt = '0;
            end
        end

        // Logic domain: merged switch, then third LDO, then core switch
        if (!ctl.logicDomainEnable || next_s.main != MS_ON) // RQ11
        begin
            next_s.lgLvl = LVL_OFF;
            next_s.lgCnt = '0;
        end
        else if (s.lgLvl != LVL_SWITCH) // RQ20
        begin
            next_s.lgCnt = bump(s.lgCnt);
            if (elapsed(s.lgCnt, STAGE_CYCLES)
                && (s.lgLvl != LVL_FIRST || pgood.mergedSwitch)
                && (s.lgLvl != LVL_SECOND || pgood.thirdLdo)) // RQ1
            begin
                next_s.lgLvl = s.lgLvl + LVL_FIRST;
                next_s.lgCnt = '0;
            end
        end

        // Processor reset release timer
        if (!ctl.resetRequest) // RQ7
        begin
            next_s.porCnt = '0;
        end
        else
        begin
            next_s.porCnt = bump(s.porCnt);
        end

        // Rail enables follow the next stage and domain levels; the standalone switch follows its control pin
        next_s.rails.earlyBuck = {3{next_s.stage >= STG_EARLY}};
        next_s.rails.midBuck = {2{next_s.stage >= STG_MID}};
        next_s.rails.secondLdo = next_s.stage >= STG_MID;
        next_s.rails.terminationLdo = next_s.fpLvl >= LVL_FIRST; // RQ17
        next_s.rails.memoryBuck = next_s.fpLvl >= LVL_SECOND;
        // Shared switch/LDO control drives the transceiver LDO
        next_s.rails.transceiverLdo = next_s.fpLvl >= LVL_SECOND; // RQ12
        // One enable for both low-voltage switches
        next_s.rails.mergedSwitch = next_s.lgLvl >= LVL_FIRST; // RQ13
        next_s.rails.thirdLdo = next_s.lgLvl >= LVL_SECOND;
        next_s.rails.standaloneSwitch = ctl.auxSwitchEnable; // RQ6

        // Open-drain pins: enable low pulls the pin low
        next_s.oeN[OD_FULL_POWER] = next_s.fpLvl == LVL_SWITCH; // RQ9
        next_s.oeN[OD_CORE] = next_s.lgLvl == LVL_SWITCH; // RQ9
        next_s.oeN[OD_RESET] = ctl.resetRequest && porReleased; // RQ18
        next_s.oeN[OD_HOST] = s.control[CTL_HOST_LEVEL]; // RQ18

        // Memory buck target and sleep flags
        if (s.control[CTL_MEM_SLEEP] && !ctl.sleepSelect) // RQ5
        begin
            next_s.vid = s.vidSleep;
        end
        else
        begin
            next_s.vid = s.vidNormal;
        end
        next_s.sleep.memoryBuck = s.control[CTL_MEM_SLEEP] & ~ctl.sleepSelect; // RQ15
        next_s.sleep.secondLdo = s.control[CTL_LDO2_SLEEP] & ctl.sleepSelect; // RQ16
        next_s.sleep.thirdLdo = s.control[CTL_LDO3_SLEEP] & ctl.sleepSelect; // RQ16

        // APB: read data captured in setup, writes take effect in access
        if (psel && !penable)
        begin
            next_s.err = !mapped(paddr);
            next_s.rdata = '0;
            if (paddr == OFF_CONTROL)
            begin
                next_s.rdata = 32'(s.control);
            end
            else if (paddr == OFF_VOLTAGE)
            begin
                next_s.rdata = 32'({s.vidSleep, s.vidNormal});
            end
            else if (paddr == OFF_STATUS)
            begin
                next_s.rdata = 32'(status);
            end
        end
        if (psel && penable && pwrite) // RQ14
        begin
            if (paddr == OFF_CONTROL)
            begin
                next_s.control = pwdata[CTL_W-1:0];
            end
            else if (paddr == OFF_VOLTAGE)
            begin
                next_s.vidNormal = pwdata[VID_W-1:0];
                next_s.vidSleep = pwdata[VID_SLEEP_LSB +: VID_W];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.main <= MS_OFF;
            s.control <= CONTROL_RST;
            s.vidNormal <= VID_NORMAL_RST; // RQ15
            s.vidSleep <= VID_SLEEP_RST;
            s.vid <= VID_NORMAL_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign prdata = s.rdata;
    assign pready = 1'b1;
    assign pslverr = s.err & psel & penable;
    assign railEn = s.rails;
    assign memBuckVid = s.vid;
    assign sleepMode = s.sleep;
    assign odOut = '0;
    assign odOeN = s.oeN;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    property p_reset_hold;
        !ctl.resetRequest |=> !odOeN[OD_RESET] ##1 !odOeN[OD_RESET];
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset out not held low"); // RQ7

    property p_reset_delay;
        $rose(odOeN[OD_RESET])
            |-> $past(s.porCnt) >= CNT_W'(RESET_CYCLES) && $past(s.main) == MS_ON;
    endproperty
    a_reset_delay: assert property (p_reset_delay) else $error("reset released early"); // RQ7

    property p_start;
        s.main == MS_OFF && mainRise |=> s.main == MS_RAMP_UP && (&railEn.earlyBuck);
    endproperty
    a_start: assert property (p_start) else $error("power-up did not start"); // RQ2

    property p_gated;
        $rose(railEn.midBuck[0]) |-> $past(&pgood.earlyBuck) && $past(stageDone);
    endproperty
    a_gated: assert property (p_gated) else $error("mid group without power good"); // RQ1

    property p_full_cut;
        !ctl.fullPowerDomainEnable |=> !railEn.terminationLdo && !railEn.memoryBuck
            && !railEn.transceiverLdo && !odOeN[OD_FULL_POWER];
    endproperty
    a_full_cut: assert property (p_full_cut) else $error("full-power domain not cut"); // RQ10

    property p_logic_cut;
        !ctl.logicDomainEnable |=> !railEn.mergedSwitch && !railEn.thirdLdo && !odOeN[OD_CORE];
    endproperty
    a_logic_cut: assert property (p_logic_cut) else $error("logic domain not cut"); // RQ11

    property p_aux;
        $changed(ctl.auxSwitchEnable) |=> railEn.standaloneSwitch == $past(ctl.auxSwitchEnable);
    endproperty
    a_aux: assert property (p_aux) else $error("standalone switch not following input"); // RQ6

    property p_sleep_vid;
        ctl.sleepSelect ##1 ctl.sleepSelect |=> memBuckVid == $past(s.vidNormal);
    endproperty
    a_sleep_vid: assert property (p_sleep_vid) else $error("wrong memory buck target"); // RQ5

    property p_down_order;
        $fell(railEn.earlyBuck[0]) |-> !railEn.midBuck[0] && !railEn.memoryBuck
            && $past(s.main) == MS_RAMP_DOWN;
    endproperty
    a_down_order: assert property (p_down_order) else $error("power-down order broken"); // RQ19

    property p_host_pin;
        psel && penable && pwrite && paddr == OFF_CONTROL
            |=> ##1 odOeN[OD_HOST] == $past(pwdata[CTL_HOST_LEVEL], 2);
    endproperty
    a_host_pin: assert property (p_host_pin) else $error("host output not set"); // RQ18

    property p_seq_on;
        s.main == MS_RAMP_UP ##1 s.main == MS_ON;
    endproperty
    c_seq_on: cover property (p_seq_on);

    property p_por_release;
        $rose(odOeN[OD_RESET]);
    endproperty
    c_por_release: cover property (p_por_release);

    property p_full_switch;
        $rose(odOeN[OD_FULL_POWER]);
    endproperty
    c_full_switch: cover property (p_full_switch);

    property p_back_off;
        s.main == MS_RAMP_DOWN ##1 s.main == MS_OFF;
    endproperty
    c_back_off: cover property (p_back_off);

endmodule : mdps_sequencer

`default_nettype wire

/* File: mdps_board_model.sv */
// Board model: rail power-good with a settable lag, pull-ups on the open-drain pins.
// Assumes the sequencer's rail and open-drain enables change on rising mclk.
`timescale 1ns/1ps
`default_nettype none

module mdps_board_model
    import mdps_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Sequencer side
    input wire mdps_rails_s railEn,
    input wire logic [3:0] odOeN,
    output mdps_rails_s pgood,
    output logic [3:0] pinLevel,
    // Board controls
    input wire logic slow,
    input wire logic pushButton,
    output logic resetRequest
);
    mdps_rails_s lag [12];

    always_ff @(posedge mclk)
    begin
        lag[0] <= railEn;
        for (int i = 1; i < 12; i++)
        begin
            lag[i] <= lag[i-1];
        end
    end

    // Good only while still enabled; a slow rail outlasts one stage delay
    assign pgood = mdps_rails_s'(railEn & (slow ? lag[11] : lag[0]));
    // Released pins are pulled high
    assign pinLevel = odOeN;
    // Pushbutton shorts the pulled-up reset request to ground
    assign resetRequest = !pushButton;
endmodule : mdps_board_model

`default_nettype wire

/* File: mdps_sequencer_test.sv */
// Self-checking bench for the power sequencer, board model on the far side.
// Assumes shortened stage and reset counts and one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module mdps_sequencer_test
    import mdps_pkg::*;
;
    localparam int SC = 8;
    localparam int RC = 20;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, button = 1'b0;
    logic aux = 1'b0, fpd = 1'b0, mainEn = 1'b0, logicEn = 1'b0, sleepSel = 1'b1;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr;
    wire logic rr;
    mdps_ctl_s ctl;
    mdps_rails_s railEn, pgood;
    logic [VID_W-1:0] memBuckVid;
    mdps_sleep_s sleepMode;
    logic [3:0] odOut, odOeN, pinLevel;
    logic [15:0] obs;
    int failures = 0;
    int comparisons = 0;

    assign ctl = {rr, aux, fpd, mainEn, logicEn, sleepSel};
    assign obs = {odOeN, railEn};

    mdps_sequencer #(.STAGE_CYCLES(SC), .RESET_CYCLES(RC)) i_dut (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ctl(ctl), .pgood(pgood), .railEn(railEn),
        .memBuckVid(memBuckVid), .sleepMode(sleepMode), .odIn(pinLevel),
        .odOut(odOut), .odOeN(odOeN));

    mdps_board_model i_board (.mclk(mclk), .railEn(railEn), .odOeN(odOeN),
        .pgood(pgood), .pinLevel(pinLevel), .slow(slow), .pushButton(button),
        .resetRequest(rr));

    initial
    begin
        forever #12.5 mclk = ~mclk;
    end

    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : tick

    task automatic waitBit(input int idx, input logic v, input int bound);
        int n = 0;
        while (obs[idx] !== v && n < bound)
        begin
            @(negedge mclk);
            n++;
        end
        check(32'(obs[idx]), 32'(v));
        if (obs[idx] !== v)
            print_verdict();
    endtask : waitBit

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (int n = 0; n < 20; n++)
        begin
            @(posedge mclk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            failures++;
            print_verdict();
        end
    endtask : apb

    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input logic ee);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, '0, rd, err);
        check(rd, exp);
        check(32'(err), 32'(ee));
    endtask : rdChk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask : wr

    task automatic t_reset();
        tick(1);
        check(32'(obs), 32'h0000_0000);
        check(32'(memBuckVid), 32'h0000_002c);
        check(32'(odOut), 32'h0000_0000);
        rdChk(OFF_CONTROL, 32'h0000_000e, 1'b0);
        rdChk(OFF_VOLTAGE, 32'h0000_302c, 1'b0);
        rdChk(12'h00c, 32'h0000_0000, 1'b1);
        $display("test reset done");
    endtask : t_reset

    task automatic t_aux();
        @(posedge mclk);
        aux <= 1'b1;
        tick(1);
        check(32'(railEn.standaloneSwitch), 32'h0000_0001);
        @(posedge mclk);
        aux <= 1'b0;
        tick(1);
        check(32'(railEn.standaloneSwitch), 32'h0000_0000);
        $display("test aux done");
    endtask : t_aux

    task automatic t_up();
        @(posedge mclk);
        slow <= 1'b1;
        fpd <= 1'b1;
        logicEn <= 1'b1;
        tick(3);
        check(32'(obs), 32'h0000_0000);
        @(posedge mclk);
        mainEn <= 1'b1;
        waitBit(0, 1'b1, 3);
        tick(SC + 2);
        check(32'(railEn.midBuck), 32'h0000_0000);
        waitBit(3, 1'b1, 40);
        waitBit(6, 1'b1, 40);
        check(32'(railEn.memoryBuck), 32'h0000_0000);
        waitBit(5, 1'b1, 40);
        check(32'(railEn.transceiverLdo), 32'h0000_0001);
        waitBit(12, 1'b1, 40);
        waitBit(15, 1'b1, 80);
        check(32'(railEn.mergedSwitch & railEn.thirdLdo), 32'h0000_0001);
        waitBit(14, 1'b1, RC + 8);
        rdChk(OFF_STATUS, 32'h001f_a7ff, 1'b0);
        $display("test power up done");
    endtask : t_up

    task automatic t_button();
        @(posedge mclk);
        button <= 1'b1;
        waitBit(14, 1'b0, 3);
        @(posedge mclk);
        button <= 1'b0;
        tick(RC - 1);
        check(32'(odOeN[OD_RESET]), 32'h0000_0000);
        waitBit(14, 1'b1, 8);
        $display("test reset button done");
    endtask : t_button

    task automatic t_sleep();
        @(posedge mclk);
        sleepSel <= 1'b0;
        tick(2);
        check(32'(memBuckVid), 32'h0000_0030);
        check(32'({sleepMode.secondLdo, sleepMode.thirdLdo}), 32'h0000_0000);
        check(32'(sleepMode.memoryBuck), 32'h0000_0001);
        @(posedge mclk);
        sleepSel <= 1'b1;
        tick(2);
        check(32'(memBuckVid), 32'h0000_002c);
        check(32'({sleepMode.secondLdo, sleepMode.thirdLdo}), 32'h0000_0003);
        check(32'(sleepMode.memoryBuck), 32'h0000_0000);
        wr(OFF_VOLTAGE, 32'h0000_3034);
        wr(OFF_CONTROL, 32'h0000_0001);
        tick(2);
        check(32'(memBuckVid), 32'h0000_0034);
        check(32'(pinLevel[OD_HOST]), 32'h0000_0001);
        @(posedge mclk);
        sleepSel <= 1'b0;
        tick(2);
        check(32'(memBuckVid), 32'h0000_0034);
        wr(OFF_CONTROL, 32'h0000_000e);
        tick(2);
        check(32'(pinLevel[OD_HOST]), 32'h0000_0000);
        $display("test sleep done");
    endtask : t_sleep

    task automatic t_domains();
        @(posedge mclk);
        fpd <= 1'b0;
        logicEn <= 1'b0;
        tick(2);
        check(32'(obs & 16'h10e0), 32'h0000_0000);
        check(32'(obs & 16'h8600), 32'h0000_0000);
        check(32'(obs & 16'h411f), 32'h0000_411f);
        @(posedge mclk);
        fpd <= 1'b1;
        logicEn <= 1'b1;
        waitBit(6, 1'b1, 40);
        check(32'(railEn.memoryBuck), 32'h0000_0000);
        waitBit(5, 1'b1, 40);
        waitBit(12, 1'b1, 40);
        waitBit(15, 1'b1, 80);
        $display("test domains done");
    endtask : t_domains

    task automatic t_down();
        @(posedge mclk);
        mainEn <= 1'b0;
        fpd <= 1'b0;
        logicEn <= 1'b0;
        tick(2);
        check(32'(obs & 16'h96e0), 32'h0000_0000);
        tick(SC - 4);
        check(32'(railEn.midBuck), 32'h0000_0003);
        waitBit(3, 1'b0, 8);
        check(32'({railEn.secondLdo, railEn.earlyBuck}), 32'h0000_0007);
        tick(SC - 3);
        check(32'(railEn.earlyBuck), 32'h0000_0007);
        waitBit(0, 1'b0, 8);
        $display("test power down done");
    endtask : t_down

    initial
    begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_aux();
        t_up();
        t_aux();
        t_button();
        t_sleep();
        t_domains();
        t_down();
        print_verdict();
    end
endmodule : mdps_sequencer_test

`default_nettype wire
